// >>> pts_defs.vh
// constants shared by the fuse-failure supervision block
// Behaviour
// - asym crit 1: 3I0 and I2 below limit
// - asym crit 2: any phase above min A
// - grounded: 3U0 and U2 above limit
// - isolated/compensated: U2/U1 above quotient
// - 3-phase crit 1: all phase voltages lost
// - 3-phase crit 2: load and small delta
// - delta current: period start minus end magnitude
// - voltage difference path only for ground source
// - difference is UG minus three times U0
// - difference above limit picks up, starts timer
// - pickup needs enable, path fail, no block
// - trip after pickup and full delay
// - pickup and trip drop when fault clears
// - early clear stops timer, zeroes, drops pickup
// - recurrence picks up, timer from zero
// - general check source: off, first CT
// - general check active while enabled
// - fuse source: off, first CT, ground voltage
// - block by event number, zero none
`ifndef PTS_DEFS_VH
`define PTS_DEFS_VH

`define PTS_REG_CTRL 8'h00
`define PTS_REG_BLOCK 8'h04
`define PTS_REG_SYM_I 8'h08
`define PTS_REG_MIN_A 8'h0C
`define PTS_REG_ASYM_V 8'h10
`define PTS_REG_QUOT 8'h14
`define PTS_REG_VLOST 8'h18
`define PTS_REG_MIN_B 8'h1C
`define PTS_REG_DIFF_I 8'h20
`define PTS_REG_DIFF_V 8'h24
`define PTS_REG_DELAY 8'h28
`define PTS_REG_STATUS 8'h2C

`define PTS_CTRL_FF_LSB 0
`define PTS_CTRL_GC_LSB 2
`define PTS_CTRL_STAR_LSB 4

`define PTS_SRC_OFF 2'h0
`define PTS_SRC_CT1 2'h1
`define PTS_SRC_CT2 2'h2
`define PTS_SRC_GND 2'h3

`define PTS_STAR_GROUNDED 2'h0

`define PTS_RST_CTRL 8'h00
`define PTS_RST_LIMIT 16'h0000

`define PTS_CLK_NS 10
`define PTS_NS_PER_MS 1000000
`define PTS_CYC_PER_MS (`PTS_NS_PER_MS / `PTS_CLK_NS)

`endif

// >>> pts_delay_timer.v
// trip delay timer counting milliseconds while the failure holds
`timescale 1ns/100ps
`include "pts_defs.vh"
module pts_delay_timer #(
    parameter CYC_PER_MS = `PTS_CYC_PER_MS
) (
    input wire clk_sys,
    input wire srst,
    input wire run,
    input wire [15:0] delay_ms,
    output reg trip,
    output reg [15:0] elapsed_ms
);

reg [31:0] pre;
wire ms_tick;

assign ms_tick = (pre == CYC_PER_MS - 1);

always @(posedge clk_sys) begin
    if (srst) begin
        pre <= 32'h00000000;
        elapsed_ms <= 16'h0000;
        trip <= 1'b0;
    end else if (!run) begin
        // early clear zeroes the count so a recurrence starts fresh
        pre <= 32'h00000000;
        elapsed_ms <= 16'h0000;
        trip <= 1'b0;
    end else begin
        if (ms_tick) begin
            pre <= 32'h00000000;
        end else begin
            pre <= pre + 32'h00000001;
        end
        // saturate at the setting; no wrap back below it
        if (ms_tick && elapsed_ms < delay_ms) begin
            elapsed_ms <= elapsed_ms + 16'h0001;
        end
        trip <= (elapsed_ms >= delay_ms);
    end
end

endmodule

// >>> pts_fuse_fail.v
// fuse-failure supervision: criteria, settings registers and events
//
// The address-and-strobe port and the address map are this design's own decisions.
`timescale 1ns/100ps
`include "pts_defs.vh"
module pts_fuse_fail #(
    parameter CYC_PER_MS = `PTS_CYC_PER_MS
) (
    input wire clk_sys,
    input wire srst,
    input wire [7:0] reg_addr,
    input wire [31:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    output reg [31:0] reg_rdata,
    input wire meas_valid,
    input wire [47:0] cur_phase,
    input wire [47:0] cur_phase_start,
    input wire [15:0] cur_residual,
    input wire [15:0] cur_negative,
    input wire [47:0] volt_phase,
    input wire [15:0] volt_residual,
    input wire [15:0] volt_negative,
    input wire [15:0] volt_positive,
    input wire [15:0] volt_ground_re,
    input wire [15:0] volt_ground_im,
    input wire [15:0] volt_zero_re,
    input wire [15:0] volt_zero_im,
    input wire [255:0] event_active,
    output reg fuse_fail_active_event,
    output reg fuse_fail_blocked_event,
    output reg fuse_fail_pickup_event,
    output wire fuse_fail_trip_event,
    output reg general_check_active_event
);

// settings
reg [7:0] ctrl;
reg [7:0] fuse_fail_block_event;
reg [15:0] symmetric_current_limit;
reg [15:0] min_load_current_limit_a;
reg [15:0] asym_voltage_limit;
reg [15:0] asym_voltage_quotient;
reg [15:0] voltage_lost_limit;
reg [15:0] min_load_current_limit_b;
reg [15:0] diff_current_limit;
reg [15:0] diff_voltage_limit;
reg [15:0] fuse_fail_trip_delay;

wire [1:0] fuse_fail_source_select;
wire [1:0] general_check_source_select;
wire [1:0] star_point_treatment;

assign fuse_fail_source_select = ctrl[`PTS_CTRL_FF_LSB +: 2];
assign general_check_source_select = ctrl[`PTS_CTRL_GC_LSB +: 2];
assign star_point_treatment = ctrl[`PTS_CTRL_STAR_LSB +: 2];

// criterion results captured once per measuring period
reg crit_asym;
reg crit_three;
reg crit_vdiff;
reg fail_cond;

wire [15:0] elapsed_ms;

// register writes
always @(posedge clk_sys) begin
    if (srst) begin
        ctrl <= `PTS_RST_CTRL;
        fuse_fail_block_event <= 8'h00;
        symmetric_current_limit <= `PTS_RST_LIMIT;
        min_load_current_limit_a <= `PTS_RST_LIMIT;
        asym_voltage_limit <= `PTS_RST_LIMIT;
        asym_voltage_quotient <= `PTS_RST_LIMIT;
        voltage_lost_limit <= `PTS_RST_LIMIT;
        min_load_current_limit_b <= `PTS_RST_LIMIT;
        diff_current_limit <= `PTS_RST_LIMIT;
        diff_voltage_limit <= `PTS_RST_LIMIT;
        fuse_fail_trip_delay <= `PTS_RST_LIMIT;
    end else if (reg_wr) begin
        case (reg_addr)
            `PTS_REG_CTRL: begin
                ctrl <= {2'h0, reg_wdata[5:0]};
            end
            `PTS_REG_BLOCK: begin
                fuse_fail_block_event <= reg_wdata[7:0];
            end
            `PTS_REG_SYM_I: begin
                symmetric_current_limit <= reg_wdata[15:0];
            end
            `PTS_REG_MIN_A: begin
                min_load_current_limit_a <= reg_wdata[15:0];
            end
            `PTS_REG_ASYM_V: begin
                asym_voltage_limit <= reg_wdata[15:0];
            end
            `PTS_REG_QUOT: begin
                asym_voltage_quotient <= reg_wdata[15:0];
            end
            `PTS_REG_VLOST: begin
                voltage_lost_limit <= reg_wdata[15:0];
            end
            `PTS_REG_MIN_B: begin
                min_load_current_limit_b <= reg_wdata[15:0];
            end
            `PTS_REG_DIFF_I: begin
                diff_current_limit <= reg_wdata[15:0];
            end
            `PTS_REG_DIFF_V: begin
                diff_voltage_limit <= reg_wdata[15:0];
            end
            `PTS_REG_DELAY: begin
                fuse_fail_trip_delay <= reg_wdata[15:0];
            end
            default: begin
            end
        endcase
    end
end

// register reads, data in the cycle after the strobe
always @(posedge clk_sys) begin
    if (srst) begin
        reg_rdata <= 32'h00000000;
    end else if (reg_rd) begin
        case (reg_addr)
            `PTS_REG_CTRL: reg_rdata <= {24'h000000, ctrl};
            `PTS_REG_BLOCK: reg_rdata <= {24'h000000, fuse_fail_block_event};
            `PTS_REG_SYM_I: reg_rdata <= {16'h0000, symmetric_current_limit};
            `PTS_REG_MIN_A: reg_rdata <= {16'h0000, min_load_current_limit_a};
            `PTS_REG_ASYM_V: reg_rdata <= {16'h0000, asym_voltage_limit};
            `PTS_REG_QUOT: reg_rdata <= {16'h0000, asym_voltage_quotient};
            `PTS_REG_VLOST: reg_rdata <= {16'h0000, voltage_lost_limit};
            `PTS_REG_MIN_B: reg_rdata <= {16'h0000, min_load_current_limit_b};
            `PTS_REG_DIFF_I: reg_rdata <= {16'h0000, diff_current_limit};
            `PTS_REG_DIFF_V: reg_rdata <= {16'h0000, diff_voltage_limit};
            `PTS_REG_DELAY: reg_rdata <= {16'h0000, fuse_fail_trip_delay};
            `PTS_REG_STATUS: begin
                reg_rdata <= {elapsed_ms, 8'h00,
                              crit_vdiff, crit_three, crit_asym,
                              general_check_active_event,
                              fuse_fail_trip_event, fuse_fail_pickup_event,
                              fuse_fail_blocked_event, fuse_fail_active_event};
            end
            default: reg_rdata <= 32'h00000000;
        endcase
    end else begin
        reg_rdata <= 32'h00000000;
    end
end

// per-phase comparisons
wire [2:0] above_min_a;
wire [2:0] above_min_b;
wire [2:0] volt_lost;
wire [2:0] delta_small;

genvar ph;
generate
    for (ph = 0; ph < 3; ph = ph + 1) begin : g_phase
        wire [15:0] i_end;
        wire [15:0] i_start;
        wire [15:0] i_delta;
        assign i_end = cur_phase[16*ph +: 16];
        assign i_start = cur_phase_start[16*ph +: 16];
        // magnitude change across the period, direction ignored
        assign i_delta = (i_end > i_start) ? (i_end - i_start)
                                           : (i_start - i_end);
        assign above_min_a[ph] = i_end > min_load_current_limit_a;
        assign above_min_b[ph] = i_end > min_load_current_limit_b;
        assign volt_lost[ph] = volt_phase[16*ph +: 16] < voltage_lost_limit;
        assign delta_small[ph] = i_delta < diff_current_limit;
    end
endgenerate

// asymmetric path
wire asym_c1;
wire asym_c2;
wire asym_c3;
wire asym_grounded;
wire asym_ratio;
wire [31:0] quot_prod;

assign asym_c1 = (cur_residual < symmetric_current_limit) &&
                 (cur_negative < symmetric_current_limit);
assign asym_c2 = |above_min_a;
assign asym_grounded = (volt_residual > asym_voltage_limit) &&
                       (volt_negative > asym_voltage_limit);
// quotient is 0.16 fixed point, so U2/U1 > q becomes U2*2^16 > q*U1
assign quot_prod = asym_voltage_quotient * volt_positive;
assign asym_ratio = {volt_negative, 16'h0000} > quot_prod;
assign asym_c3 = (star_point_treatment == `PTS_STAR_GROUNDED) ? asym_grounded
                                                               : asym_ratio;

// three-phase path
wire three_c1;
wire three_c2;

assign three_c1 = &volt_lost;
assign three_c2 = (|above_min_b) && (&delta_small);

// residual voltage difference, UG - 3*U0 as complex value
wire signed [18:0] ug_re;
wire signed [18:0] ug_im;
wire signed [18:0] u0_re;
wire signed [18:0] u0_im;
wire signed [18:0] dif_re;
wire signed [18:0] dif_im;
wire signed [37:0] sq_re;
wire signed [37:0] sq_im;
wire [37:0] sq_re_u;
wire [37:0] sq_im_u;
wire [38:0] dif_sq;
wire [31:0] lim_sq;

assign ug_re = {{3{volt_ground_re[15]}}, volt_ground_re};
assign ug_im = {{3{volt_ground_im[15]}}, volt_ground_im};
assign u0_re = {{3{volt_zero_re[15]}}, volt_zero_re};
assign u0_im = {{3{volt_zero_im[15]}}, volt_zero_im};
assign dif_re = ug_re - ((u0_re <<< 1) + u0_re);
assign dif_im = ug_im - ((u0_im <<< 1) + u0_im);
// squared magnitudes avoid a square root at the cost of wide multipliers
assign sq_re = dif_re * dif_re;
assign sq_im = dif_im * dif_im;
assign sq_re_u = sq_re;
assign sq_im_u = sq_im;
assign dif_sq = {1'b0, sq_re_u} + {1'b0, sq_im_u};
assign lim_sq = diff_voltage_limit * diff_voltage_limit;

// source decode
wire src_ct1;
wire src_gnd;
wire ff_enabled;
wire blocked_now;
wire path_fail;

// the unsupported second current channel counts as off
assign src_ct1 = (fuse_fail_source_select == `PTS_SRC_CT1);
assign src_gnd = (fuse_fail_source_select == `PTS_SRC_GND);
assign ff_enabled = src_ct1 || src_gnd;
assign blocked_now = (fuse_fail_block_event != 8'h00) &&
                     event_active[fuse_fail_block_event];
// ground source ignores every asymmetric and three-phase limit
assign path_fail = src_ct1 ? (crit_asym || crit_three)
                           : (src_gnd && crit_vdiff);

// criteria latched at each measuring period strobe
always @(posedge clk_sys) begin
    if (srst) begin
        crit_asym <= 1'b0;
        crit_three <= 1'b0;
        crit_vdiff <= 1'b0;
    end else if (meas_valid) begin
        crit_asym <= asym_c1 && asym_c2 && asym_c3;
        crit_three <= three_c1 && three_c2;
        crit_vdiff <= src_gnd && (dif_sq > {7'h00, lim_sq});
    end
end

// pickup state and status events
always @(posedge clk_sys) begin
    if (srst) begin
        fail_cond <= 1'b0;
        fuse_fail_pickup_event <= 1'b0;
        fuse_fail_active_event <= 1'b0;
        fuse_fail_blocked_event <= 1'b0;
        general_check_active_event <= 1'b0;
    end else begin
        fail_cond <= ff_enabled && path_fail && !blocked_now;
        // pickup follows the condition both ways, no latching
        fuse_fail_pickup_event <= ff_enabled && path_fail && !blocked_now;
        fuse_fail_active_event <= ff_enabled;
        fuse_fail_blocked_event <= ff_enabled && blocked_now;
        general_check_active_event <=
            (general_check_source_select == `PTS_SRC_CT1);
    end
end

// timer runs only while pickup stands; dropping pickup clears it
pts_delay_timer #(
    .CYC_PER_MS(CYC_PER_MS)
) u_timer (
    .clk_sys(clk_sys),
    .srst(srst),
    .run(fail_cond && fuse_fail_pickup_event),
    .delay_ms(fuse_fail_trip_delay),
    .trip(fuse_fail_trip_event),
    .elapsed_ms(elapsed_ms)
);

endmodule

// >>> pts_fuse_fail_checker.sv
// port assertions for the fuse-failure supervision block
`timescale 1ns/100ps
`include "pts_defs.vh"
module pts_fuse_fail_checker #(
    parameter CYC_PER_MS = `PTS_CYC_PER_MS
) (
    input wire clk_sys,
    input wire srst,
    input wire [7:0] reg_addr,
    input wire [31:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    input wire [31:0] reg_rdata,
    input wire fuse_fail_active_event,
    input wire fuse_fail_blocked_event,
    input wire fuse_fail_pickup_event,
    input wire fuse_fail_trip_event,
    input wire general_check_active_event
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (srst);
    sequence ctrl_wr_s;
        reg_wr && reg_addr == `PTS_REG_CTRL;
    endsequence
    sequence blocked_s;
        fuse_fail_blocked_event [*2];
    endsequence
    rdata_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
        else $error("read data not zero outside read answer");
    gc_on_a: assert property (ctrl_wr_s ##0 (reg_wdata[3:2] == `PTS_SRC_CT1)
        |-> ##2 general_check_active_event) else $error("general check not active");
    gc_off_a: assert property (ctrl_wr_s ##0 (reg_wdata[3:2] != `PTS_SRC_CT1)
        |-> ##2 !general_check_active_event) else $error("general check active");
    ff_on_a: assert property (ctrl_wr_s ##0 (reg_wdata[0])
        |-> ##2 fuse_fail_active_event) else $error("fuse check not active");
    ff_off_a: assert property (ctrl_wr_s ##0 (!reg_wdata[0])
        |-> ##2 !fuse_fail_active_event) else $error("fuse check active");
    inactive_pk_a: assert property (!fuse_fail_active_event [*3]
        |-> !fuse_fail_pickup_event) else $error("pickup while disabled");
    block_hold_a: assert property (blocked_s |-> !fuse_fail_pickup_event)
        else $error("pickup while blocked");
    trip_rise_a: assert property ($rose(fuse_fail_trip_event)
        |-> $past(fuse_fail_pickup_event)) else $error("trip without pickup");
    trip_drop_a: assert property (fuse_fail_trip_event
        |-> fuse_fail_pickup_event || $past(fuse_fail_pickup_event))
        else $error("trip outlived pickup");
endmodule
bind pts_fuse_fail pts_fuse_fail_checker #(.CYC_PER_MS(CYC_PER_MS)) u_chk (
    .clk_sys(clk_sys), .srst(srst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .fuse_fail_active_event(fuse_fail_active_event),
    .fuse_fail_blocked_event(fuse_fail_blocked_event),
    .fuse_fail_pickup_event(fuse_fail_pickup_event),
    .fuse_fail_trip_event(fuse_fail_trip_event),
    .general_check_active_event(general_check_active_event));

// >>> pts_meas_model.sv
// measurement front end model: fixed quantities for each fault mode
`timescale 1ns/100ps
module pts_meas_model (
    input wire clk_sys,
    input wire [2:0] mode,
    output reg meas_valid = 1'b0,
    output wire [47:0] cur_phase,
    output wire [47:0] cur_start,
    output wire [15:0] cur_res,
    output wire [47:0] volt_phase,
    output wire [15:0] volt_sym,
    output wire [15:0] vg_re,
    output wire [15:0] vz_re
);
    reg [2:0] cnt = 3'h0;
    wire lost = mode == 3'h2 || mode == 3'h4;
    always @(posedge clk_sys) begin
        cnt <= cnt + 3'h1;
        meas_valid <= cnt == 3'h7;
    end
    // mode 4: current step across the period, a short circuit and not a fuse
    assign cur_phase = {3{16'h00C8}};
    assign cur_start = {3{mode == 3'h4 ? 16'h0064 : 16'h00C8}};
    assign cur_res = mode == 3'h5 ? 16'h01F4 : 16'h000A;
    assign volt_phase = lost ? {3{16'h000A}} : mode == 3'h1 ? 48'h03E8_03E8_0000 : {3{16'h03E8}};
    assign volt_sym = mode == 3'h1 || mode == 3'h5 ? 16'h01F4 : 16'h000A;
    assign vg_re = mode == 3'h3 || mode == 3'h6 ? 16'h012C : 16'h0000;
    assign vz_re = mode == 3'h6 ? 16'h0064 : 16'h0000;
endmodule

// >>> testbench.sv
// self-checking bench for the fuse-failure supervision block
`timescale 1ns/100ps
`include "pts_defs.vh"
module testbench;
    reg clk_sys = 1'b0;
    reg srst = 1'b1;
    reg [7:0] reg_addr = 8'h00;
    reg [31:0] reg_wdata = 32'h0;
    reg reg_wr = 1'b0;
    reg reg_rd = 1'b0;
    reg [255:0] ev = 256'h0;
    reg [2:0] mode = 3'h0;
    integer n_fail;
    integer cmp_count;
    wire [31:0] reg_rdata;
    wire mv, ff_act, ff_blk, ff_pk, ff_trip, gc_act;
    wire [47:0] cur_phase, cur_start, volt_phase;
    wire [15:0] cur_res, volt_sym, vg_re, vz_re;
    pts_meas_model u_pts_meas_model (.clk_sys(clk_sys), .mode(mode), .meas_valid(mv),
        .cur_phase(cur_phase), .cur_start(cur_start), .cur_res(cur_res),
        .volt_phase(volt_phase), .volt_sym(volt_sym), .vg_re(vg_re), .vz_re(vz_re));
    pts_fuse_fail #(.CYC_PER_MS(4)) u_pts_fuse_fail (.clk_sys(clk_sys), .srst(srst),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .meas_valid(mv), .cur_phase(cur_phase),
        .cur_phase_start(cur_start), .cur_residual(cur_res), .cur_negative(16'h000A),
        .volt_phase(volt_phase), .volt_residual(volt_sym), .volt_negative(volt_sym),
        .volt_positive(16'h03E8), .volt_ground_re(vg_re), .volt_ground_im(16'h0000),
        .volt_zero_re(vz_re), .volt_zero_im(16'h0000), .event_active(ev),
        .fuse_fail_active_event(ff_act), .fuse_fail_blocked_event(ff_blk),
        .fuse_fail_pickup_event(ff_pk), .fuse_fail_trip_event(ff_trip),
        .general_check_active_event(gc_act));
    initial begin
        forever #5 clk_sys = ~clk_sys;
    end
    task print_verdict;
        begin
            $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
            if (n_fail == 0 && cmp_count > 0)
                $display("Finished cleanly");
            else
                $display("Finished with errors");
            $finish;
        end
    endtask
    task check(input [31:0] seen, input [31:0] exp);
        begin
            cmp_count = cmp_count + 1;
            if (seen !== exp) begin
                n_fail = n_fail + 1;
                $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
            end
        end
    endtask
    task wr(input [7:0] a, input [31:0] d);
        begin
            @(posedge clk_sys);
            reg_addr <= a;
            reg_wdata <= d;
            reg_wr <= 1'b1;
            @(posedge clk_sys);
            reg_wr <= 1'b0;
        end
    endtask
    task rd(input [7:0] a, input [31:0] exp);
        begin
            @(posedge clk_sys);
            reg_addr <= a;
            reg_rd <= 1'b1;
            @(posedge clk_sys);
            reg_rd <= 1'b0;
            #1;
            check(reg_rdata, exp);
        end
    endtask
    // bounded wait on pickup (s=0) or trip (s=1); a timeout ends the run
    task wt(input s, input e, input integer n);
        integer i;
        begin
            for (i = 0; i < n && (s ? ff_trip : ff_pk) !== e; i = i + 1)
                @(posedge clk_sys) #1;
            check(s ? ff_trip : ff_pk, e);
            if ((s ? ff_trip : ff_pk) !== e)
                print_verdict;
        end
    endtask
    task hold(input integer n);
        begin
            repeat (n) @(posedge clk_sys);
            #1;
        end
    endtask
    task go(input [2:0] m);
        begin
            @(posedge clk_sys) mode <= m;
        end
    endtask
    task t_regs;
        begin
            rd(`PTS_REG_CTRL, 32'h0);
            rd(`PTS_REG_DELAY, 32'h0);
            wr(`PTS_REG_CTRL, 32'hFF);
            rd(`PTS_REG_CTRL, 32'h3F);
            wr(`PTS_REG_CTRL, 32'h0);
            wr(`PTS_REG_STATUS, 32'hFFFFFFFF);
            rd(`PTS_REG_STATUS, 32'h0);
            rd(8'h30, 32'h0);
            wr(`PTS_REG_SYM_I, 32'hABCD0064);
            rd(`PTS_REG_SYM_I, 32'h64);
            wr(`PTS_REG_MIN_A, 32'h32);
            wr(`PTS_REG_ASYM_V, 32'h64);
            wr(`PTS_REG_QUOT, 32'h4000);
            wr(`PTS_REG_VLOST, 32'h64);
            wr(`PTS_REG_MIN_B, 32'h32);
            wr(`PTS_REG_DIFF_I, 32'h14);
            wr(`PTS_REG_DIFF_V, 32'h64);
            wr(`PTS_REG_DELAY, 32'h3);
            $display("test registers done");
        end
    endtask
    task t_asym;
        begin
            wr(`PTS_REG_CTRL, 32'h05);
            go(3'h5);
            hold(20);
            check(ff_pk, 0);
            go(3'h1);
            wt(0, 1, 12);
            check(gc_act, 1);
            hold(8);
            check(ff_trip, 0);
            wt(1, 1, 16);
            go(3'h0);
            wt(0, 0, 12);
            wt(1, 0, 2);
            wr(`PTS_REG_CTRL, 32'h11);
            go(3'h1);
            wt(0, 1, 12);
            go(3'h0);
            wt(0, 0, 12);
            $display("test asymmetric done");
        end
    endtask
    task t_three;
        begin
            wr(`PTS_REG_CTRL, 32'h01);
            go(3'h4);
            hold(20);
            check(ff_pk, 0);
            go(3'h3);
            hold(20);
            check(ff_pk, 0);
            go(3'h2);
            wt(0, 1, 12);
            go(3'h0);
            wt(0, 0, 12);
            wr(`PTS_REG_CTRL, 32'h03);
            go(3'h1);
            hold(20);
            check(ff_pk, 0);
            go(3'h6);
            hold(20);
            check(ff_pk, 0);
            go(3'h3);
            wt(0, 1, 12);
            go(3'h0);
            wt(0, 0, 12);
            $display("test three-phase and difference done");
        end
    endtask
    task t_early;
        begin
            wr(`PTS_REG_CTRL, 32'h01);
            wr(`PTS_REG_DELAY, 32'h5);
            go(3'h1);
            wt(0, 1, 12);
            hold(4);
            go(3'h0);
            wt(0, 0, 12);
            check(ff_trip, 0);
            go(3'h1);
            wt(0, 1, 12);
            hold(12);
            check(ff_trip, 0);
            wt(1, 1, 16);
            go(3'h0);
            wt(0, 0, 12);
            $display("test early clear done");
        end
    endtask
    task t_block;
        begin
            wr(`PTS_REG_BLOCK, 32'h07);
            @(posedge clk_sys) ev <= 256'h80;
            go(3'h1);
            hold(20);
            check({ff_blk, ff_pk}, 2'b10);
            @(posedge clk_sys) ev <= 256'h0;
            wt(0, 1, 12);
            check(ff_blk, 0);
            wr(`PTS_REG_BLOCK, 32'h0);
            @(posedge clk_sys) ev <= 256'h1;
            hold(4);
            check({ff_blk, ff_pk}, 2'b01);
            wr(`PTS_REG_CTRL, 32'h0A);
            hold(4);
            check({ff_act, gc_act, ff_pk}, 3'b000);
            go(3'h0);
            @(posedge clk_sys) ev <= 256'h0;
            $display("test blocking and sources done");
        end
    endtask
    initial begin
        n_fail = 0;
        cmp_count = 0;
        repeat (8) @(posedge clk_sys);
        srst <= 1'b0;
        t_regs;
        t_asym;
        t_three;
        t_early;
        t_block;
        print_verdict;
    end
endmodule
